// ===== tvap_regs.svh
`ifndef TVAP_REGS_SVH
`define TVAP_REGS_SVH

// Protective functions carried through every vote
`define TVAP_NFUNC       5
`define TVAP_FN_CELL     0
`define TVAP_FN_PURGE    1
`define TVAP_FN_TRITIUM  2
`define TVAP_FN_DROPOUT  3
`define TVAP_FN_FILLSTOP 4
`define TVAP_NSAFE       4
`define TVAP_ALL_FN      5'h1f
`define TVAP_NO_FN       5'h00
`define TVAP_SAFE_FN     5'h0f

// Sensor measurement width
`define TVAP_SENS_W      8

// Register indices on the plain register port
`define TVAP_ADDR_W      4
`define TVAP_REG_MODE    4'h0
`define TVAP_REG_SETPT0  4'h1
`define TVAP_REG_SETPT4  4'h5
`define TVAP_REG_TRIP    4'h6
`define TVAP_REG_ACT     4'h7
`define TVAP_REG_TEST    4'h8

// Reset values
`define TVAP_SETPT_RST   8'h80
`define TVAP_DIVC_FUNCS  5'h07

`endif

// ===== tvap_pkg.sv
`include "tvap_regs.svh"

package tvap_pkg;

    // Operator-selected operating mode, one-hot
    typedef enum logic [4:0] {
        TVAP_MODE_IDLE     = 5'h01,
        TVAP_MODE_FILL     = 5'h02,
        TVAP_MODE_IRRAD    = 5'h04,
        TVAP_MODE_DUMP     = 5'h08,
        TVAP_MODE_TRANSFER = 5'h10
    } tvap_mode_type;

    // One division's measured values, one word per function
    typedef struct packed {
        logic [`TVAP_NFUNC-1:0][`TVAP_SENS_W-1:0] value;
    } tvap_sensor_type;

    // One safety data bus from a voting module to the interface modules
    typedef struct packed {
        logic                   live;
        logic [`TVAP_NFUNC-1:0] demand;
    } tvap_bus_type;

    // Non-safety status towards the plant control system
    typedef struct packed {
        tvap_mode_type              mode;
        logic [2:0][`TVAP_NFUNC-1:0] trip;
        logic [2:0]                 bypassed;
        logic [`TVAP_NSAFE-1:0]     actuated;
        logic                       fill_stop;
        logic [1:0]                 selftest_fail;
    } tvap_status_type;

    // Two-out-of-three coincidence, bitwise per function
    function automatic logic [`TVAP_NFUNC-1:0] vote2(input logic [`TVAP_NFUNC-1:0] a,
                                                     input logic [`TVAP_NFUNC-1:0] b,
                                                     input logic [`TVAP_NFUNC-1:0] c);
        vote2 = (a & b) | (a & c) | (b & c);
    endfunction

endpackage

// ===== tvap_trip_det.sv
`timescale 1ns/1ps
`default_nettype none
`include "tvap_regs.svh"

// One trip-determination module of one division
module tvap_trip_det (
    input  wire logic                   clk_sys_in,
    input  wire logic                   sys_rst_in,
    input  wire tvap_pkg::tvap_sensor_type value_in,
    input  wire logic [`TVAP_NFUNC-1:0][`TVAP_SENS_W-1:0] setpt_in,
    input  wire logic [`TVAP_NFUNC-1:0] enable_in,
    input  wire logic                   oos_in,
    input  wire logic                   trip_sel_in,
    output logic      [`TVAP_NFUNC-1:0] demand_out,
    output logic                        bypassed_out
);
    import tvap_pkg::*;

    typedef struct packed {
        logic [`TVAP_NFUNC-1:0] demand;   // Registered trip demand per function
        logic                   bypassed; // Module held in maintenance bypass
    } tvap_trip_state_type;

    tvap_trip_state_type st_q;
    tvap_trip_state_type st_d;

    // Setpoint compare, overridden by the out-of-service switch
    always_comb begin
        st_d = st_q;
        for (int f = 0; f < `TVAP_NFUNC; f++) begin
            st_d.demand[f] = enable_in[f] && (value_in.value[f] >= setpt_in[f]);
        end
        st_d.bypassed = 1'b0;
        if (oos_in) begin
            if (trip_sel_in) begin
                // Forced trip: every channel demands, whatever the mode
                st_d.demand = `TVAP_ALL_FN;
            end else begin
                // Bypass: no channel contributes to any vote
                st_d.demand   = `TVAP_NO_FN;
                st_d.bypassed = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign demand_out   = st_q.demand;
    assign bypassed_out = st_q.bypassed;

endmodule
`default_nettype wire

// ===== tvap_vote.sv
`timescale 1ns/1ps
`default_nettype none
`include "tvap_regs.svh"

// One schedule/bypass/vote module; drives one safety data bus
module tvap_vote (
    input  wire logic                   clk_sys_in,
    input  wire logic                   sys_rst_in,
    input  wire logic [`TVAP_NFUNC-1:0] demand_a_in,
    input  wire logic [`TVAP_NFUNC-1:0] demand_b_in,
    input  wire logic [`TVAP_NFUNC-1:0] demand_c_in,
    output tvap_pkg::tvap_bus_type      bus_out
);
    import tvap_pkg::*;

    typedef struct packed {
        tvap_bus_type bus; // Registered bus word
    } tvap_vote_state_type;

    tvap_vote_state_type st_q;
    tvap_vote_state_type st_d;

    // Per-function coincidence across the three divisions
    always_comb begin
        st_d            = st_q;
        st_d.bus.demand = vote2(demand_a_in, demand_b_in, demand_c_in);
        st_d.bus.live   = 1'b1;
    end

    // Live stays low in reset so receivers treat the bus as demanding
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign bus_out = st_q.bus;

endmodule
`default_nettype wire

// ===== tvap_protector.sv
`timescale 1ns/1ps
`default_nettype none
`include "tvap_regs.svh"

// How it works
// - Voter demands when two divisions demand
// - Voters only in divisions A and B
// - Three voter outputs on separate buses
// - Interface module actuates on two-of-three buses
// - Component actuates only when both de-energize
// - Out-of-service switch selects bypass or trip
// - Forced state applies to all module channels
// - Operator selects modes; logic applies interlocks
// - Setpoint crossing forces safe state, any mode
// - Inputs reach two or three divisions
// - Fill valve position goes to hardwired path
// - Status and values reported to plant control
// - Four safety outputs plus fill stop
// - Single channel fault never trips; blocks only two-division functions
// - Setpoint-free voters carry self-test
// - Interface voting has no self-test circuitry
// - De-energized drive means actuated component
// - Reset or loss fails into safe state
module tvap_protector #(
    parameter logic [`TVAP_NFUNC-1:0] DIVC_FUNCS = `TVAP_DIVC_FUNCS
) (
    input  wire logic                    clk_sys_in,
    input  wire logic                    sys_rst_in,
    input  wire logic [`TVAP_ADDR_W-1:0] reg_addr_in,
    input  wire logic [31:0]             reg_wdata_in,
    input  wire logic                    reg_wr_in,
    input  wire logic                    reg_rd_in,
    output logic      [31:0]             reg_rdata_out,
    input  wire tvap_pkg::tvap_sensor_type sensor_a_in,
    input  wire tvap_pkg::tvap_sensor_type sensor_b_in,
    input  wire tvap_pkg::tvap_sensor_type sensor_c_in,
    input  wire logic [2:0]              oos_in,
    input  wire logic [2:0]              trip_sel_in,
    input  wire logic                    fill_valve_open_in,
    output logic      [`TVAP_NSAFE-1:0]  drive_a_out,
    output logic      [`TVAP_NSAFE-1:0]  drive_b_out,
    output logic                         fill_stop_out,
    output tvap_pkg::tvap_status_type    status_out
);
    import tvap_pkg::*;

    // Entire block state; pin synchronisers live here too
    typedef struct packed {
        tvap_mode_type                              mode;       // Operator mode
        logic [`TVAP_NFUNC-1:0][`TVAP_SENS_W-1:0]   setpt;      // Trip setpoints
        tvap_sensor_type [2:0]                      sens_meta;  // Sensor first stage
        tvap_sensor_type [2:0]                      sens_sync;  // Sensor second stage
        logic [2:0]                                 oos_meta;   // Switch first stage
        logic [2:0]                                 oos_sync;   // Switch second stage
        logic [2:0]                                 sel_meta;   // Selector first stage
        logic [2:0]                                 sel_sync;   // Selector second stage
        logic                                       valve_meta; // Valve first stage
        logic                                       valve_sync; // Valve second stage
        logic [1:0]                                 test_fail;  // Sticky voter mismatch
        logic [`TVAP_NSAFE-1:0]                     drive_a;    // Interface A drive
        logic [`TVAP_NSAFE-1:0]                     drive_b;    // Interface B drive
        logic                                       fill_stop;  // Non-safety fill stop
        logic [31:0]                                rdata;      // Read answer
        tvap_status_type                            status;     // Plant control status
    } tvap_top_state_type;

    tvap_top_state_type st_q;
    tvap_top_state_type st_d;

    // Trip-determination results, one row per division
    logic [2:0][`TVAP_NFUNC-1:0] trip_demand;
    logic [2:0]                  trip_bypassed;
    // Per-division function enables after routing and mode interlocks
    logic [2:0][`TVAP_NFUNC-1:0] div_enable;
    // Three buses from each actuating division
    tvap_bus_type [1:0][2:0]     bus;

    // Fixed operating sequence; the logic never steps it on its own
    function automatic tvap_mode_type next_mode(input tvap_mode_type m);
        case (m)
            TVAP_MODE_IDLE:     next_mode = TVAP_MODE_FILL;
            TVAP_MODE_FILL:     next_mode = TVAP_MODE_IRRAD;
            TVAP_MODE_IRRAD:    next_mode = TVAP_MODE_DUMP;
            TVAP_MODE_DUMP:     next_mode = TVAP_MODE_TRANSFER;
            TVAP_MODE_TRANSFER: next_mode = TVAP_MODE_IDLE;
            default:            next_mode = TVAP_MODE_IDLE;
        endcase
    endfunction

    // Mode-specific enables: safety functions stay armed in every mode,
    // fill stop only matters while the vessel is being filled
    function automatic logic [`TVAP_NFUNC-1:0] mode_enable(input tvap_mode_type m);
        mode_enable = `TVAP_SAFE_FN;
        if (m == TVAP_MODE_FILL) begin
            mode_enable = `TVAP_ALL_FN;
        end
    endfunction

    // Interface module vote on three buses; a dead bus counts as demand
    // so a broken link never holds off actuation
    function automatic logic [`TVAP_NFUNC-1:0] eim_vote(input tvap_bus_type b0,
                                                        input tvap_bus_type b1,
                                                        input tvap_bus_type b2);
        eim_vote = vote2(b0.demand | {`TVAP_NFUNC{~b0.live}},
                         b1.demand | {`TVAP_NFUNC{~b1.live}},
                         b2.demand | {`TVAP_NFUNC{~b2.live}});
    endfunction

    // Division C only receives the variables wired to it
    always_comb begin
        div_enable[0] = mode_enable(st_q.mode);
        div_enable[1] = mode_enable(st_q.mode);
        div_enable[2] = mode_enable(st_q.mode) & DIVC_FUNCS;
    end

    // One trip-determination module per division; each sees several sensors
    for (genvar d = 0; d < 3; d++) begin : g_trip
        tvap_trip_det u_trip (
            .clk_sys_in   (clk_sys_in),
            .sys_rst_in   (sys_rst_in),
            .value_in     (st_q.sens_sync[d]),
            .setpt_in     (st_q.setpt),
            .enable_in    (div_enable[d]),
            .oos_in       (st_q.oos_sync[d]),
            .trip_sel_in  (st_q.sel_sync[d]),
            .demand_out   (trip_demand[d]),
            .bypassed_out (trip_bypassed[d])
        );
    end

    // Three redundant voters in divisions A and B only; division C holds
    // none, its trip results merely feed the voters of the other two
    for (genvar d = 0; d < 2; d++) begin : g_div
        for (genvar v = 0; v < 3; v++) begin : g_voter
            tvap_vote u_vote (
                .clk_sys_in  (clk_sys_in),
                .sys_rst_in  (sys_rst_in),
                .demand_a_in (trip_demand[0]),
                .demand_b_in (trip_demand[1]),
                .demand_c_in (trip_demand[2]),
                .bus_out     (bus[d][v])
            );
        end
    end

    // Next-state logic for the whole block
    always_comb begin
        logic [`TVAP_NFUNC-1:0] eim_a;
        logic [`TVAP_NFUNC-1:0] eim_b;
        logic [1:0]             mismatch;
        logic [1:0]             test_clr;
        tvap_mode_type          req;
        eim_a    = '0;
        eim_b    = '0;
        mismatch = '0;
        test_clr = '0;
        req      = TVAP_MODE_IDLE;
        st_d     = st_q;

        // Two-stage synchronisers on the sensor, switch, selector and valve inputs
        st_d.sens_meta[0] = sensor_a_in;
        st_d.sens_meta[1] = sensor_b_in;
        st_d.sens_meta[2] = sensor_c_in;
        st_d.sens_sync    = st_q.sens_meta;
        st_d.oos_meta     = oos_in;
        st_d.oos_sync     = st_q.oos_meta;
        st_d.sel_meta     = trip_sel_in;
        st_d.sel_sync     = st_q.sel_meta;
        st_d.valve_meta   = fill_valve_open_in;
        st_d.valve_sync   = st_q.valve_meta;

        // Register writes
        if (reg_wr_in) begin
            case (reg_addr_in)
                `TVAP_REG_MODE: begin
                    // Only the operator moves the mode: one step forward,
                    // or back to idle; anything else is ignored
                    req = tvap_mode_type'(reg_wdata_in[4:0]);
                    if (req == next_mode(st_q.mode) || req == TVAP_MODE_IDLE) begin
                        st_d.mode = req;
                    end
                end
                `TVAP_REG_TEST: begin
                    test_clr = reg_wdata_in[1:0];
                end
                default: begin
                    if (reg_addr_in >= `TVAP_REG_SETPT0 && reg_addr_in <= `TVAP_REG_SETPT4) begin
                        for (int f = 0; f < `TVAP_NFUNC; f++) begin
                            if (reg_addr_in == `TVAP_REG_SETPT0 + `TVAP_ADDR_W'(f)) begin
                                st_d.setpt[f] = reg_wdata_in[`TVAP_SENS_W-1:0];
                            end
                        end
                    end
                end
            endcase
        end

        // Interface modules: each division votes its three buses per
        // function; plain gating, checked by functional test instead of
        // built-in self-test
        eim_a = eim_vote(bus[0][0], bus[0][1], bus[0][2]);
        eim_b = eim_vote(bus[1][0], bus[1][1], bus[1][2]);

        // Drive high means energized; a trip de-energizes
        st_d.drive_a = ~eim_a[`TVAP_NSAFE-1:0];
        st_d.drive_b = ~eim_b[`TVAP_NSAFE-1:0];

        // Non-safety fill stop: voted demand, or the hardwired valve
        // indication showing the fill valve open outside the fill mode
        st_d.fill_stop = eim_a[`TVAP_FN_FILLSTOP] | eim_b[`TVAP_FN_FILLSTOP] |
                         (st_q.valve_sync && st_q.mode != TVAP_MODE_FILL);

        // Voter self-test: the three redundant voters of a division must
        // agree; a mismatch sticks until cleared, a new one wins the clear
        for (int d = 0; d < 2; d++) begin
            mismatch[d] = (bus[d][0] != bus[d][1]) || (bus[d][0] != bus[d][2]);
        end
        st_d.test_fail = (st_q.test_fail & ~test_clr) | mismatch;

        // Status towards plant control, refreshed every cycle
        st_d.status.mode          = st_q.mode;
        st_d.status.trip          = trip_demand;
        st_d.status.bypassed      = trip_bypassed;
        // Component is actuated only when both drives are dropped
        st_d.status.actuated      = ~st_q.drive_a & ~st_q.drive_b;
        st_d.status.fill_stop     = st_q.fill_stop;
        st_d.status.selftest_fail = st_q.test_fail;

        // Read answer stands for one cycle only
        st_d.rdata = '0;
        if (reg_rd_in) begin
            case (reg_addr_in)
                `TVAP_REG_MODE: begin
                    st_d.rdata[4:0] = st_q.mode;
                end
                `TVAP_REG_TRIP: begin
                    st_d.rdata[3*`TVAP_NFUNC-1:0] = trip_demand;
                    st_d.rdata[18:16]             = trip_bypassed;
                end
                `TVAP_REG_ACT: begin
                    st_d.rdata[3:0]   = st_q.drive_a;
                    st_d.rdata[7:4]   = st_q.drive_b;
                    st_d.rdata[11:8]  = st_q.status.actuated;
                    st_d.rdata[12]    = st_q.fill_stop;
                    st_d.rdata[16]    = st_q.valve_sync;
                end
                `TVAP_REG_TEST: begin
                    st_d.rdata[1:0] = st_q.test_fail;
                end
                default: begin
                    for (int f = 0; f < `TVAP_NFUNC; f++) begin
                        if (reg_addr_in == `TVAP_REG_SETPT0 + `TVAP_ADDR_W'(f)) begin
                            st_d.rdata[`TVAP_SENS_W-1:0] = st_q.setpt[f];
                        end
                    end
                end
            endcase
        end
    end

    // State register; reset leaves every drive de-energized so the
    // plant sits actuated until the votes say otherwise
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            st_q         <= '0;
            st_q.mode    <= TVAP_MODE_IDLE;
            st_q.setpt   <= {`TVAP_NFUNC{`TVAP_SETPT_RST}};
            st_q.status.mode <= TVAP_MODE_IDLE;
            st_q.status.actuated <= `TVAP_NSAFE'(`TVAP_SAFE_FN);
        end else begin
            st_q <= st_d;
        end
    end

    // A single bad channel reaches at most one division's trip result,
    // which one voter input alone cannot turn into a trip; it holds one off for functions outside DIVC_FUNCS
    assign drive_a_out   = st_q.drive_a;
    assign drive_b_out   = st_q.drive_b;
    assign fill_stop_out = st_q.fill_stop;
    assign status_out    = st_q.status;
    assign reg_rdata_out = st_q.rdata;

endmodule
`default_nettype wire

// ===== tvap_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "tvap_regs.svh"
// Port-level watch on the protector; bound onto the top module below
module tvap_monitor import tvap_pkg::*; (
    input wire logic                   clk_sys_in,
    input wire logic                   sys_rst_in,
    input wire logic                   reg_wr_in,
    input wire logic                   reg_rd_in,
    input wire logic [31:0]            reg_rdata_out,
    input wire logic [2:0]             oos_in,
    input wire logic [2:0]             trip_sel_in,
    input wire logic                   fill_valve_open_in,
    input wire logic [`TVAP_NSAFE-1:0] drive_a_out,
    input wire logic [`TVAP_NSAFE-1:0] drive_b_out,
    input wire logic                   fill_stop_out,
    input wire tvap_status_type        status_out
);
    default clocking mon_cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);

    // Reset must leave every component de-energized, so reset checks ignore the disable
    a_rst_safe: assert property (disable iff (1'b0)
        sys_rst_in |=> drive_a_out == 4'h0 && drive_b_out == 4'h0 && !fill_stop_out)
        else $error("outputs not safe after reset");
    a_rst_mode: assert property (disable iff (1'b0)
        sys_rst_in |=> status_out.mode == TVAP_MODE_IDLE) else $error("mode not idle after reset");
    // Read data only in the slot after a read, zero otherwise
    a_rdata_quiet: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
        else $error("read data outside its slot");
    // Component state follows both drives one cycle later
    a_act_both_low: assert property (
        status_out.actuated == ~($past(drive_a_out) | $past(drive_b_out)))
        else $error("actuated status does not match drives");
    a_fill_echo: assert property (status_out.fill_stop == $past(fill_stop_out))
        else $error("fill stop status lags wrongly");
    // Divisions A and B forced to trip: five pipeline edges, then everything actuated
    a_forced_trip: assert property (
        (&{oos_in[1:0], trip_sel_in[1:0]})[*5] |=> drive_a_out == 4'h0 && drive_b_out == 4'h0)
        else $error("forced trip did not actuate");
    // One tripped division with the others bypassed is a single vote only
    a_lone_trip: assert property (
        (oos_in == 3'h7 && trip_sel_in == 3'h1)[*8] |=> drive_a_out == 4'hf && drive_b_out == 4'hf)
        else $error("single division caused actuation");
    // No write in the window keeps the status mode equal to the live mode
    a_valve_stop: assert property (
        (fill_valve_open_in && !reg_wr_in && status_out.mode != TVAP_MODE_FILL)[*4] |=> fill_stop_out)
        else $error("open valve outside fill gave no stop");

    c_forced: cover property (&{oos_in[1:0], trip_sel_in[1:0]} && drive_a_out == 4'h0);
    c_lone: cover property (oos_in == 3'h7 && trip_sel_in == 3'h1 && drive_b_out == 4'hf);
    c_valve: cover property (fill_valve_open_in && fill_stop_out);
endmodule

bind tvap_protector tvap_monitor tvap_monitor_inst (.clk_sys_in, .sys_rst_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .oos_in, .trip_sel_in, .fill_valve_open_in, .drive_a_out,
    .drive_b_out, .fill_stop_out, .status_out);
`default_nettype wire

// ===== tvap_plant.sv
`timescale 1ns/1ps
`default_nettype none
`include "tvap_regs.svh"
// Actuated plant components, each fed from both actuating divisions
module tvap_plant (
    input  wire logic [`TVAP_NSAFE-1:0] drive_a_in,
    input  wire logic [`TVAP_NSAFE-1:0] drive_b_in,
    output logic      [`TVAP_NSAFE-1:0] actuated_out
);
    // Spring-return load: stays off only while either drive is energized
    assign actuated_out = ~(drive_a_in | drive_b_in);
endmodule
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tvap_pkg::*;
    localparam logic [4:0] DIVC = 5'h07;                             // Functions wired to C
    localparam logic [5:0] SW_TBL [4] = '{6'h39, 6'h1b, 6'h38, 6'h24}; // Switch corners
    logic            clk_sys_in = 1'b0;
    logic            sys_rst_in = 1'b1;
    logic [3:0]      reg_addr   = 4'h0;
    logic [31:0]     reg_wdata  = 32'h0;
    logic            reg_wr     = 1'b0;
    logic            reg_rd     = 1'b0;
    logic [2:0]      out_of_service_switch        = 3'h0;
    logic [2:0]      sel        = 3'h0;
    logic            valve      = 1'b0;
    tvap_sensor_type sens [3]   = '{default: '0};
    logic [31:0]     rdata, rd_val;
    logic [3:0]      drv_a, drv_b, plant_act;
    logic            fill_stop;
    tvap_status_type status;
    logic [5:0]      sw;
    int              errors = 0;
    int              n_checks = 0;
    int              setpt [5] = '{default: 8'h80};
    int              dem [3];                                        // Model demand per division
    int              mode_idx = 0;                                   // Model mode as bit index
    int              w, f;

    always #12.5 clk_sys_in = ~clk_sys_in;

    tvap_protector #(.DIVC_FUNCS(DIVC)) tvap_protector_inst (.clk_sys_in, .sys_rst_in,
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_rdata_out(rdata), .sensor_a_in(sens[0]), .sensor_b_in(sens[1]),
        .sensor_c_in(sens[2]), .oos_in(out_of_service_switch), .trip_sel_in(sel), .fill_valve_open_in(valve),
        .drive_a_out(drv_a), .drive_b_out(drv_b), .fill_stop_out(fill_stop), .status_out(status));
    tvap_plant tvap_plant_inst (.drive_a_in(drv_a), .drive_b_in(drv_b), .actuated_out(plant_act));

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // One-cycle strobes; the next access waits for a fresh edge
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a);
        @(posedge clk_sys_in);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd <= 1'b0;
        #1 rd_val = rdata;
    endtask

    // Integer model: forced switches override sensors, then two-of-three per function
    task automatic model(output logic [3:0] drv, output logic fs);
        int votes;
        for (int d = 0; d < 3; d++) begin
            dem[d] = 0;
            for (int g = 0; g < 5; g++)
                if (sens[d].value[g] >= setpt[g] && (g < 4 || mode_idx == 1) && (d < 2 || DIVC[g]))
                    dem[d] |= 1 << g;
            if (out_of_service_switch[d])
                dem[d] = sel[d] ? 31 : 0;
        end
        for (int g = 0; g < 5; g++) begin
            votes = ((dem[0] >> g) & 1) + ((dem[1] >> g) & 1) + ((dem[2] >> g) & 1);
            if (g < 4)
                drv[g] = !(votes >= 2);
            else
                fs = votes >= 2 || (valve && mode_idx != 1);
        end
    endtask

    // Eight edges cover the five-edge sensor path plus the status stage
    task automatic settle_and_compare();
        logic [3:0] e_drv;
        logic       e_fs;
        logic [14:0] e_trip;
        repeat (8) @(posedge clk_sys_in);
        #1;
        model(e_drv, e_fs);
        e_trip = 15'(dem[0] | dem[1] << 5 | dem[2] << 10);
        check(32'(drv_a), 32'(e_drv), "drive a");
        check(32'(drv_b), 32'(e_drv), "drive b");
        check(32'(plant_act), {28'h0, ~e_drv}, "plant state");
        check(32'(status.actuated), {28'h0, ~e_drv}, "status actuated");
        check(32'(fill_stop), 32'(e_fs), "fill stop");
        check(32'(status.trip), 32'(e_trip), "status trip");
        check(32'({status.selftest_fail, status.bypassed}), 32'(out_of_service_switch & ~sel), "status flags");
        check(32'(status.mode), 32'h1 << mode_idx, "status mode");
        reg_read(4'h6);
        check(rd_val, {13'h0, out_of_service_switch & ~sel, 1'h0, e_trip}, "trip word");
        reg_read(4'h7);
        check(rd_val, {15'h0, valve, 3'h0, e_fs, ~e_drv, e_drv, e_drv}, "act word");
    endtask

    // Hang guard; the run itself needs about 1300 cycles
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        errors++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(22730));
        repeat (4) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        #1;
        check(32'(drv_a), 32'h0, "drive after reset");
        // Reset values; indexes 6 and 7 depend on live inputs, 9 up are unmapped
        for (int a = 0; a < 16; a++) begin
            if (a < 6 || a > 7) begin
                reg_read(4'(a));
                check(rd_val, a == 0 ? 32'h1 : a < 6 ? 32'h80 : 32'h0, "reset value");
            end
        end
        // Random mode steps, setpoints and inputs; first four use switch corners
        for (int i = 0; i < 60; i++) begin
            w = $urandom % 5;
            reg_write(4'h0, 32'h1 << w);
            if (w == 0 || w == (mode_idx + 1) % 5)
                mode_idx = w;
            reg_read(4'h0);
            check(rd_val, 32'h1 << mode_idx, "mode");
            f = $urandom % 5;
            setpt[f] = $urandom % 256;
            reg_write(4'(f + 1), 32'(setpt[f]));
            reg_read(4'(f + 1));
            check(rd_val, 32'(setpt[f]), "setpoint");
            sw = i < 4 ? SW_TBL[i] : 6'($urandom);
            @(posedge clk_sys_in);
            for (int d = 0; d < 3; d++)
                for (int g = 0; g < 5; g++)
                    sens[d].value[g] <= 8'($urandom);
            out_of_service_switch <= sw[5:3];
            sel <= sw[2:0];
            valve <= 1'($urandom);
            settle_and_compare();
        end
        // Second reset in mid-run must return to the safe idle state
        @(posedge clk_sys_in);
        sys_rst_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        mode_idx = 0;
        #1;
        check(32'(drv_b), 32'h0, "drive after second reset");
        reg_read(4'h0);
        check(rd_val, 32'h1, "mode after second reset");
        tally_and_finish();
    end
endmodule
`default_nettype wire
